/* File: rtl/pll_cfg_device.sv */
/*
 * Device end: serial input register, control / reference / feedback / test
 * latches and the digital dividers and lock detect they steer.
 * Assumes link pins are synchronous to clock; clock stands in for the
 * oscillator, ref_tick marks each reference input cycle.
 */
// Contract
// - output divider field sets divided output ratio
// - host writes zero divider when output unused
// - output is divider result or halved
// - host zeroes feedback word spare bits
// - feedback count field is feedback divide value
// - total feedback division equals feedback count
// - feedback word bit 21 selects pump gain
// - pump gain follows latest of two writes
// - select code 01 stores reference word
// - reference count field is reference ratio
// - bits 16-17 set anti-backlash width
// - lock after five or three good cycles
// - test word ignored unless test bit set
// - bits 20-21 divide band-select clock
// - host advised band-select divide of eight
// - host zeroes reference word spare bits
// - 24 bits shift in, strobe transfers
// - select code 00 stores control word
// - power-down holds counters, serial stays live
module pll_cfg_device
    import pll_cfg_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    serial_load_if.device              link,
    input  wire logic                  ref_tick,
    input  wire logic                  phase_err_ok,
    output logic                       divided_clock_output,
    output logic                       feedback_pulse,
    output logic                       reference_pulse,
    output logic                       band_select_tick,
    output logic                       locked,
    output logic                       power_down,
    output logic                       pump_gain_select,
    output logic [1:0]                 antibacklash_width,
    output logic                       factory_test_active,
    output logic [WORD_W-1:0]          test_word
);
    // =====================================================================
    // serial input register
    logic [WORD_W-1:0] shift_q;
    logic              sclk_prev_q;
    logic              load_prev_q;
    logic              sclk_rise;
    logic              load_rise;

    assign sclk_rise = link.serial_clock && !sclk_prev_q;
    assign load_rise = link.load_strobe && !load_prev_q;

    // edge history; pins are already synchronous so no synchroniser
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
            load_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= link.serial_clock;
            load_prev_q <= link.load_strobe;
        end
    end

    // msb first, one bit per rising serial clock; never gated by power-down
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[WORD_W-2:0], link.serial_data};
        end
    end

    logic [1:0] sel;
    assign sel = shift_q[SEL_LSB +: 2];

    // =====================================================================
    // latches
    logic [WORD_W-1:0] control_q;
    logic [WORD_W-1:0] reference_q;
    logic [WORD_W-1:0] feedback_q;
    logic [WORD_W-1:0] test_q;

    // transfer on load strobe rising edge into the selected latch
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            control_q   <= '0;
            reference_q <= '0;
            feedback_q  <= '0;
            test_q      <= '0;
        end else if (load_rise) begin
            unique case (sel)
                SEL_CONTROL:   control_q   <= shift_q;
                SEL_REFERENCE: reference_q <= shift_q;
                SEL_FEEDBACK:  feedback_q  <= shift_q;
                SEL_TEST:      test_q      <= shift_q;
            endcase
        end
    end

    // pump gain: whichever of the two words wrote it last
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pump_gain_select <= 1'b0;
        end else if (load_rise && sel == SEL_CONTROL) begin
            pump_gain_select <= shift_q[CTRL_GAIN_BIT];
        end else if (load_rise && sel == SEL_FEEDBACK) begin
            pump_gain_select <= shift_q[FB_GAIN_BIT];
        end
    end

    // =====================================================================
    // decoded fields
    logic [OUTDIV_W-1:0]   out_ratio;
    logic [FBCOUNT_W-1:0]  fb_ratio;
    logic [REFCOUNT_W-1:0] ref_ratio;
    logic                  hold_counters;
    logic                  halve_mode;
    logic [2:0]            lock_need;

    assign out_ratio     = feedback_q[OUTDIV_LSB +: OUTDIV_W];
    assign fb_ratio      = feedback_q[FBCOUNT_LSB +: FBCOUNT_W];
    assign ref_ratio     = reference_q[REFCOUNT_LSB +: REFCOUNT_W];
    assign halve_mode    = control_q[CTRL_HALF_BIT];
    assign hold_counters = control_q[CTRL_PD1_BIT] || control_q[CTRL_CNT_RST_BIT];
    assign lock_need     = reference_q[LDP_BIT] ? LOCK_CYCLES_FINE : LOCK_CYCLES_COARSE;

    // registered status copies of the latches
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            power_down          <= 1'b0;
            antibacklash_width  <= 2'h0;
            factory_test_active <= 1'b0;
            test_word           <= '0;
        end else begin
            power_down          <= control_q[CTRL_PD1_BIT];
            antibacklash_width  <= reference_q[ABW_LSB +: 2];
            factory_test_active <= reference_q[TMB_BIT];
            // test latch has no effect while the test bit is clear
            test_word           <= reference_q[TMB_BIT] ? test_q : '0;
        end
    end

    // =====================================================================
    // dividers
    logic out_pulse;
    logic fb_pulse;
    logic ref_pulse;
    logic bsc_pulse;

    // output divider runs off the oscillator; ratio below two is not legal
    prog_divider #(.W(OUTDIV_W)) u_out_div (
        .clock (clock),
        .rst   (rst),
        .hold  (hold_counters),
        .tick  (1'b1),
        .ratio (out_ratio),
        .pulse (out_pulse)
    );

    // feedback division is the count field alone, no prescaler
    prog_divider #(.W(FBCOUNT_W)) u_fb_div (
        .clock (clock),
        .rst   (rst),
        .hold  (hold_counters),
        .tick  (1'b1),
        .ratio (fb_ratio),
        .pulse (fb_pulse)
    );

    prog_divider #(.W(REFCOUNT_W)) u_ref_div (
        .clock (clock),
        .rst   (rst),
        .hold  (hold_counters),
        .tick  (ref_tick),
        .ratio (ref_ratio),
        .pulse (ref_pulse)
    );

    // band select clock: reference output, optionally divided by 2, 4, 8
    prog_divider #(.W(4)) u_bsc_div (
        .clock (clock),
        .rst   (rst),
        .hold  (hold_counters),
        .tick  (ref_pulse),
        .ratio (bsc_ratio(reference_q[BSC_LSB +: 2])),
        .pulse (bsc_pulse)
    );

    // divided output: direct pulse train or a 50% toggle at half the rate
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            divided_clock_output <= 1'b0;
        end else if (hold_counters || out_ratio == '0) begin
            divided_clock_output <= 1'b0;
        end else if (halve_mode) begin
            divided_clock_output <= divided_clock_output ^ out_pulse;
        end else begin
            divided_clock_output <= out_pulse;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            feedback_pulse   <= 1'b0;
            reference_pulse  <= 1'b0;
            band_select_tick <= 1'b0;
        end else begin
            feedback_pulse   <= fb_pulse;
            reference_pulse  <= ref_pulse;
            band_select_tick <= bsc_pulse;
        end
    end

    // =====================================================================
    // lock detect
    logic [2:0] good_q;

    // consecutive good reference cycles; one bad cycle starts over
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            good_q <= 3'h0;
            locked <= 1'b0;
        end else if (hold_counters) begin
            good_q <= 3'h0;
            locked <= 1'b0;
        end else if (ref_pulse) begin
            if (!phase_err_ok) begin
                good_q <= 3'h0;
                locked <= 1'b0;
            end else begin
                if (good_q < lock_need) begin
                    good_q <= good_q + 3'h1;
                end
                locked <= (good_q + 3'h1 >= lock_need);
            end
        end
    end
endmodule : pll_cfg_device

/* File: rtl/pll_cfg_pkg.sv */
/*
 * Shared constants for the three-wire configuration link of the integer-N
 * clock synthesizer: word layout, latch select codes, field positions.
 * Assumes both ends and the bench import it whole.
 */
package pll_cfg_pkg;
    // =====================================================================
    // word and latch select
    localparam int         WORD_W         = 24;
    localparam logic [1:0] SEL_CONTROL    = 2'h0;
    localparam logic [1:0] SEL_REFERENCE  = 2'h1;
    localparam logic [1:0] SEL_FEEDBACK   = 2'h2;
    localparam logic [1:0] SEL_TEST       = 2'h3;
    localparam int         SEL_LSB        = 0;

    // =====================================================================
    // feedback divider word
    localparam int OUTDIV_LSB   = 2;
    localparam int OUTDIV_W     = 5;
    localparam int FBCOUNT_LSB  = 8;
    localparam int FBCOUNT_W    = 13;
    localparam int FB_GAIN_BIT  = 21;
    localparam int FB_SPARE_LO  = 7;
    localparam int SPARE_HI_A   = 22;
    localparam int SPARE_HI_B   = 23;

    // =====================================================================
    // reference divider word
    localparam int REFCOUNT_LSB = 2;
    localparam int REFCOUNT_W   = 14;
    localparam int ABW_LSB      = 16;
    localparam int LDP_BIT      = 18;
    localparam int TMB_BIT      = 19;
    localparam int BSC_LSB      = 20;
    localparam logic [1:0] BSC_DIV8 = 2'h3;

    // =====================================================================
    // control word
    localparam int CTRL_CNT_RST_BIT = 4;
    localparam int CTRL_HALF_BIT    = 5;
    localparam int CTRL_GAIN_BIT    = 10;
    localparam int CTRL_PD1_BIT     = 20;

    // =====================================================================
    // lock detect
    localparam logic [2:0] LOCK_CYCLES_FINE   = 3'h5;
    localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;

    // band select divide ratio from its two-bit code: 1, 2, 4, 8
    function automatic logic [3:0] bsc_ratio(input logic [1:0] code);
        bsc_ratio = 4'h1 << code;
    endfunction : bsc_ratio
endpackage : pll_cfg_pkg

/* File: rtl/serial_load_if.sv */
/*
 * Three-wire serial load link: serial clock, data and load strobe, all
 * driven by the host. Assumes both ends run on the same system clock.
 */
interface serial_load_if;
    logic serial_clock;
    logic serial_data;
    logic load_strobe;

    modport host   (output serial_clock, output serial_data, output load_strobe);
    modport device (input  serial_clock, input  serial_data, input  load_strobe);
endinterface : serial_load_if

/* File: rtl/prog_divider.sv */
/*
 * Programmable terminal counter: one-cycle pulse every ratio ticks.
 * Assumes ratio is held stable by the owner; hold forces the load state.
 */
module prog_divider
    import pll_cfg_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         hold,
    input  wire logic         tick,
    input  wire logic [W-1:0] ratio,
    output logic              pulse
);
    logic [W-1:0] count_q;

    // count up to ratio-1; ratio zero means stopped
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= '0;
            pulse   <= 1'b0;
        end else if (hold || ratio == '0) begin
            count_q <= '0;
            pulse   <= 1'b0;
        end else if (tick) begin
            pulse <= (count_q == ratio - W'(1));
            if (count_q >= ratio - W'(1)) begin
                count_q <= '0;  // also recovers if ratio shrank mid-count
            end else begin
                count_q <= count_q + W'(1);
            end
        end else begin
            pulse <= 1'b0;
        end
    end
endmodule : prog_divider

/* File: rtl/pll_cfg_host.sv */
/*
 * Host end: takes 24-bit words from the user side and shifts them out on
 * the three-wire link, msb first, then pulses the load strobe.
 * Assumes the device samples on rising serial clock and strobe edges.
 */
module pll_cfg_host
    import pll_cfg_pkg::*;
#(
    parameter int HALF_CYCLES = 4
) (
    input  wire logic              clock,
    input  wire logic              rst,
    serial_load_if.host            link,
    input  wire logic              cmd_valid,
    input  wire logic [WORD_W-1:0] cmd_word,
    input  wire logic              divided_clock_output_unused,
    input  wire logic              band_div_default,
    output logic                   cmd_ready
);
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_LOW    = 3'b001,
        ST_HIGH   = 3'b010,
        ST_STROBE = 3'b011
    } host_state_t;

    host_state_t       state_q;
    logic [WORD_W-1:0] word_q;
    logic [4:0]        bits_q;
    logic [7:0]        wait_q;
    logic [WORD_W-1:0] clean;

    // =====================================================================
    // word sanitising
    always_comb begin
        clean = cmd_word;
        unique case (cmd_word[SEL_LSB +: 2])
            SEL_FEEDBACK: begin
                clean[SPARE_HI_B]  = 1'b0;
                clean[SPARE_HI_A]  = 1'b0;
                clean[FB_SPARE_LO] = 1'b0;
                if (divided_clock_output_unused) begin
                    clean[OUTDIV_LSB +: OUTDIV_W] = '0;
                end
            end
            SEL_REFERENCE: begin
                clean[SPARE_HI_B] = 1'b0;
                clean[SPARE_HI_A] = 1'b0;
                clean[TMB_BIT]    = 1'b0;
                if (band_div_default) begin
                    clean[BSC_LSB +: 2] = BSC_DIV8;
                end
            end
            default: ;
        endcase
    end

    // =====================================================================
    // serialiser
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q           <= ST_IDLE;
            word_q            <= '0;
            bits_q            <= 5'h0;
            wait_q            <= 8'h0;
            cmd_ready         <= 1'b1;
            link.serial_clock <= 1'b0;
            link.serial_data  <= 1'b0;
            link.load_strobe  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    link.load_strobe <= 1'b0;
                    if (cmd_valid && cmd_ready) begin
                        word_q           <= {clean[WORD_W-2:0], 1'b0};
                        link.serial_data <= clean[WORD_W-1];
                        bits_q           <= 5'(WORD_W - 1);
                        wait_q           <= 8'(HALF_CYCLES - 1);
                        cmd_ready        <= 1'b0;
                        state_q          <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    // data settles a half period before the rising edge
                    if (wait_q == 8'h0) begin
                        link.serial_clock <= 1'b1;
                        wait_q            <= 8'(HALF_CYCLES - 1);
                        state_q           <= ST_HIGH;
                    end else begin
                        wait_q <= wait_q - 8'h1;
                    end
                end
                ST_HIGH: begin
                    if (wait_q == 8'h0) begin
                        link.serial_clock <= 1'b0;
                        wait_q            <= 8'(HALF_CYCLES - 1);
                        if (bits_q == 5'h0) begin
                            state_q <= ST_STROBE;
                        end else begin
                            link.serial_data <= word_q[WORD_W-1];
                            word_q           <= {word_q[WORD_W-2:0], 1'b0};
                            bits_q           <= bits_q - 5'h1;
                            state_q          <= ST_LOW;
                        end
                    end else begin
                        wait_q <= wait_q - 8'h1;
                    end
                end
                ST_STROBE: begin
                    // strobe high for one half period after all 24 bits
                    link.load_strobe <= 1'b1;
                    if (wait_q == 8'h0) begin
                        cmd_ready <= 1'b1;
                        state_q   <= ST_IDLE;
                    end else begin
                        wait_q <= wait_q - 8'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule : pll_cfg_host

/* File: bench/pll_cfg_monitor.sv */
/*
 * Checker for the three-wire link and the latches it fills.
 * Assumes one clock domain with rst async active high.
 */
module pll_cfg_monitor
    import pll_cfg_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              serial_clock,
    input wire logic              serial_data,
    input wire logic              load_strobe,
    input wire logic              divided_clock_output_unused,
    input wire logic              band_div_default,
    input wire logic              pump_gain_select,
    input wire logic [1:0]        antibacklash_width,
    input wire logic              power_down,
    input wire logic              locked,
    input wire logic              feedback_pulse,
    input wire logic              factory_test_active,
    input wire logic [WORD_W-1:0] test_word
);
    timeunit 1ns;
    timeprecision 100ps;

    // =====================================================================
    // shadow shift register
    logic [WORD_W-1:0] sh_q;
    logic [WORD_W-1:0] word_q;
    logic [5:0]        bits_q;
    logic              sck_q;
    logic              ls_q;
    wire               sck_rise = serial_clock & ~sck_q;
    wire               ld       = load_strobe & ~ls_q;
    wire  [1:0]        sel      = sh_q[1:0];

    // bit count restarts at each strobe, so a short word shows up
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_q  <= 1'b0;
            ls_q   <= 1'b0;
            bits_q <= 6'h00;
            sh_q   <= 24'h000000;
            word_q <= 24'h000000;
        end else begin
            sck_q  <= serial_clock;
            ls_q   <= load_strobe;
            bits_q <= ld ? 6'h00 : bits_q + 6'(sck_rise);
            if (sck_rise) sh_q <= {sh_q[WORD_W-2:0], serial_data};
            if (ld) word_q <= sh_q;
        end
    end

    // =====================================================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_full_word; ld |-> bits_q == 6'h18; endproperty
    property p_fb_gain; ld && sel == SEL_FEEDBACK |-> ##[1:2] pump_gain_select == word_q[FB_GAIN_BIT]; endproperty
    property p_ctl_gain; ld && sel == SEL_CONTROL |-> ##[1:2] pump_gain_select == word_q[CTRL_GAIN_BIT]; endproperty
    property p_ctl_pd; ld && sel == SEL_CONTROL |-> ##[1:2] power_down == word_q[CTRL_PD1_BIT]; endproperty
    property p_abw; ld && sel == SEL_REFERENCE |-> ##[1:2] antibacklash_width == word_q[ABW_LSB+:2]; endproperty
    property p_band8; ld && sel == SEL_REFERENCE && band_div_default |-> sh_q[BSC_LSB+:2] == BSC_DIV8; endproperty
    property p_unused; ld && sel == SEL_FEEDBACK && divided_clock_output_unused |-> sh_q[OUTDIV_LSB+:OUTDIV_W] == 5'h00; endproperty
    property p_tmb; ld && sel == SEL_REFERENCE |-> ##2 !sh_q[TMB_BIT] && test_word == 24'h0 && !factory_test_active;
    endproperty
    property p_pd_hold; power_down [*3] |-> !feedback_pulse && !locked; endproperty
    // divider words must reach the device with their spare bits cleared
    property p_spare; ld && sel[1] != sel[0] |-> sh_q[SPARE_HI_B-:2] == 2'h0 && !(sel[1] && sh_q[FB_SPARE_LO]);
    endproperty

    a_full_word: assert property (p_full_word)
        else $error("strobe without a full word");
    a_fb_gain: assert property (p_fb_gain)
        else $error("gain not taken from feedback word");
    a_ctl_gain: assert property (p_ctl_gain)
        else $error("gain not taken from control word");
    a_ctl_pd: assert property (p_ctl_pd)
        else $error("control word not latched");
    a_abw: assert property (p_abw)
        else $error("anti-backlash width wrong");
    a_band8: assert property (p_band8)
        else $error("band divide not forced to eight");
    a_unused: assert property (p_unused)
        else $error("unused output divider not zero");
    a_tmb: assert property (p_tmb)
        else $error("test latch not ignored");
    a_pd_hold: assert property (p_pd_hold)
        else $error("counters run in power down");
    a_spare: assert property (p_spare)
        else $error("spare bits not cleared");

    c_ref: cover property (ld && sel == SEL_REFERENCE);
    c_fb: cover property (ld && sel == SEL_FEEDBACK);
    c_pd: cover property (power_down [*3]);
endmodule : pll_cfg_monitor

/* File: bench/tb_pll_counter_latch_config.sv */
/*
 * Bench: host and device face each other over the link; a model of
 * the latches is compared after every word. Assumes ref_tick each cycle.
 */
module tb_pll_counter_latch_config
    import pll_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clock, rst, cmd_valid, cmd_ready, divided_clock_output_unused, band_div_default, phase_err_ok;
    logic [WORD_W-1:0] cmd_word, test_word;
    logic              divided_clock_output, feedback_pulse, reference_pulse, band_select_tick, locked;
    logic              power_down, pump_gain_select, factory_test_active;
    logic [1:0]        antibacklash_width;
    int                miscompares, checked, cycles, m_gain, m_pd, m_abw, p, r, a, b;
    int                t[2];
    int unsigned       seed = 93;
    wire  [4:0]        mon = {locked, band_select_tick, reference_pulse, feedback_pulse, divided_clock_output};

    serial_load_if lk ();
    pll_cfg_host #(.HALF_CYCLES(1)) pll_cfg_host_i (.clock, .rst, .link(lk.host), .cmd_valid, .cmd_word,
        .divided_clock_output_unused, .band_div_default, .cmd_ready);
    pll_cfg_device pll_cfg_device_i (.clock, .rst, .link(lk.device), .ref_tick(1'b1), .phase_err_ok,
        .divided_clock_output, .feedback_pulse, .reference_pulse, .band_select_tick, .locked, .power_down,
        .pump_gain_select, .antibacklash_width, .factory_test_active, .test_word);
    pll_cfg_monitor pll_cfg_monitor_i (.clock, .rst, .serial_clock(lk.serial_clock),
        .serial_data(lk.serial_data), .load_strobe(lk.load_strobe), .divided_clock_output_unused, .band_div_default,
        .pump_gain_select, .antibacklash_width, .power_down, .locked, .feedback_pulse,
        .factory_test_active, .test_word);

    // =====================================================================
    // helpers
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [23:0] rw(input int bd, input int lock_precision_select, input int ab, input int rc);
        return {2'h0, 2'(bd), 1'h0, 1'(lock_precision_select), 2'(ab), 14'(rc), SEL_REFERENCE};
    endfunction : rw

    function automatic logic [23:0] fw(input int g, input int bc, input int ac);
        return {2'h0, 1'(g), 13'(bc), 1'h0, 5'(ac), SEL_FEEDBACK};
    endfunction : fw

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic check_regs();
        chk(24'(pump_gain_select), 24'(m_gain));
        chk(24'(antibacklash_width), 24'(m_abw));
        chk(24'(power_down), 24'(m_pd));
        chk(test_word, 24'h0);
        chk(24'(factory_test_active), 24'h0);
    endtask : check_regs

    // one word through the host, then the model follows the select code
    task automatic send(input logic [23:0] w);
        int n;
        @(negedge clock);
        cmd_word = w;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        repeat (4) @(negedge clock);
        case (w[1:0])
            SEL_CONTROL: begin
                m_gain = w[CTRL_GAIN_BIT];
                m_pd = w[CTRL_PD1_BIT];
            end
            SEL_REFERENCE: m_abw = w[ABW_LSB+:2];
            SEL_FEEDBACK: m_gain = w[FB_GAIN_BIT];
            default: ;
        endcase
        check_regs();
    endtask : send

    // spacing of the 2nd and 3rd rise; the first may still carry the old ratio
    task automatic period(input int k, output int sp);
        int r0, hits;
        logic prev;
        prev = mon[k];
        hits = 0;
        r0 = 0;
        sp = -1;
        for (int n = 0; n < 1000 && hits < 3; n++) begin
            @(negedge clock);
            if (mon[k] === 1'b1 && prev !== 1'b1) begin
                hits++;
                if (hits == 3) sp = n - r0;
                r0 = n;
            end
            prev = mon[k];
        end
    endtask : period

    // =====================================================================
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            finish_test();
        end
    end

    // =====================================================================
    // main sequence
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_word = 24'h000000;
        divided_clock_output_unused = 1'b0;
        band_div_default = 1'b0;
        phase_err_ok = 1'b1;
        repeat (5) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check_regs();
        // every band code and width, random reference ratio
        r = 2 + xs() % 12;
        for (int c = 0; c < 4; c++) begin
            send(rw(c, 0, c, r));
            period(3, p);
            chk(24'(p), 24'(r << c));
        end
        period(2, p);
        chk(24'(p), 24'(r));
        band_div_default = 1'b1;
        send(rw(0, 0, 1, r) | 24'hC80000);
        period(3, p);
        chk(24'(p), 24'(r * 8));
        band_div_default = 1'b0;
        // divider extremes, both output modes, gain from both words
        for (int i = 0; i < 4; i++) begin
            a = i[0] ? 31 : 2;
            b = (i == 0) ? 3 : 3 + xs() % 40;
            send((24'(i[1]) << CTRL_HALF_BIT) | (24'(xs() % 2) << CTRL_GAIN_BIT));
            send(fw(xs() % 2, b, a));
            period(1, p);
            chk(24'(p), 24'(b));
            period(0, p);
            chk(24'(p), 24'(i[1] ? 2 * a : a));
        end
        divided_clock_output_unused = 1'b1;
        send(fw(0, 9, 5) | 24'hC00080);
        period(0, p);
        chk(24'(p), 24'hFFFFFF);
        divided_clock_output_unused = 1'b0;
        send(24'(xs()) | 24'(SEL_TEST));
        // lock time differs by two reference cycles between precisions
        for (int l = 1; l >= 0; l--) begin
            send(rw(0, l, 0, 1));
            phase_err_ok = 1'b0;
            repeat (10) @(negedge clock);
            phase_err_ok = 1'b1;
            t[l] = 0;
            while (locked !== 1'b1 && t[l] < 100) begin
                @(negedge clock);
                t[l]++;
            end
        end
        chk(24'(t[1] - t[0]), 24'h000002);
        // power down holds counters but the link keeps latching
        send(24'h1 << CTRL_PD1_BIT);
        send(rw(0, 0, 2, 5));
        period(1, p);
        chk(24'(p), 24'hFFFFFF);
        send(24'h000000);
        finish_test();
    end
endmodule : tb_pll_counter_latch_config
